// ---- logic/serial_mode_cfg.svh ----
// serial_mode_cfg.svh: offsets, field positions, codes and counts as macros.
// assumes: included by its bare name from every design file that needs it.
`ifndef SERIAL_MODE_CFG_SVH
`define SERIAL_MODE_CFG_SVH

// ----------------------------------------
// mode byte layout
// ----------------------------------------
`define SM_MODE_RST   8'h4C
`define SM_IF_HI      1
`define SM_IF_LO      0
`define SM_LEN_HI     3
`define SM_LEN_LO     2
`define SM_PAR_HI     5
`define SM_PAR_LO     4
`define SM_STOP_HI    7
`define SM_STOP_LO    6

// ----------------------------------------
// field codes
// ----------------------------------------
`define SM_IF_RS232   2'h0
`define SM_IF_FOUR    2'h1
`define SM_IF_TWO     2'h3
`define SM_LEN_7      2'h2
`define SM_LEN_8      2'h3
`define SM_PAR_NONE   2'h0
`define SM_PAR_EVEN   2'h3
`define SM_PAR_ODD    2'h1
`define SM_STOP_1     2'h1
`define SM_STOP_2     2'h3

// ----------------------------------------
// timing and sizes
// ----------------------------------------
`define SM_BAUD_DIV   1736
`define SM_FIFO_DEPTH 16
`define SM_FIFO_WIDTH 8

`endif

// ---- logic/serial_mode_pkg.sv ----
// serial_mode_pkg: types shared by the serial mode block.
// assumes: serial_mode_cfg.svh holds all numeric constants.
package serial_mode_pkg;

	// configurable pin function; HS_A is cts/dcd/rts, HS_B is dtr (pin three)
	typedef enum logic [2:0] {
		FN_IN   = 3'h0,
		FN_OUT  = 3'h1,
		FN_LAMP = 3'h2,
		FN_TXEN = 3'h3,
		FN_HS_A = 3'h4,
		FN_HS_B = 3'h5
	} pin_fn_e;

	// transmit and receive engine states, one-hot
	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_START = 5'h02,
		ST_DATA  = 5'h04,
		ST_PAR   = 5'h08,
		ST_STOP  = 5'h10
	} line_st_e;

endpackage : serial_mode_pkg

// ---- logic/serial_fifo.sv ----
// serial_fifo: flip-flop FIFO with valid/ready on both sides.
// assumes: one clock, asynchronous active-low reset.
`include "serial_mode_cfg.svh"
module serial_fifo #(
	parameter int W     = `SM_FIFO_WIDTH,
	parameter int DEPTH = `SM_FIFO_DEPTH
) (
	// clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rstn,
	// fill side
	input  wire logic         i_valid,
	input  wire logic [W-1:0] i_data,
	output logic              o_ready,
	// drain side
	output logic              o_valid,
	output logic [W-1:0]      o_data,
	input  wire logic         i_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];   // storage
	logic [AW-1:0] wr_ptr;       // next write slot
	logic [AW-1:0] rd_ptr;       // next read slot
	logic [AW:0]   count;        // words held
	logic          push;
	logic          pop;

	assign o_ready = (count != (AW+1)'(DEPTH));
	assign o_valid = (count != '0);
	assign o_data  = mem[rd_ptr];
	assign push    = i_valid && o_ready;
	assign pop     = o_valid && i_ready;

	// storage write, no reset needed on data
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_ptr] <= i_data;
		end
	end

	// pointers and fill count
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// never holds more than its depth
	fifo_bound_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		count <= (AW+1)'(DEPTH))
		else $error("fifo count beyond depth");
	// a refused push leaves the count alone
	fifo_full_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(!o_ready && !i_ready) |=> count == (AW+1)'(DEPTH))
		else $error("fifo full count moved");

endmodule : serial_fifo

// ---- logic/serial_mode_txen.sv ----
// serial_mode_txen: mode byte, framing engines, pin mux and line driver enable.
// assumes: all inputs synchronous to I_CLK; one line transceiver outside.
//
// Summary of operation
// (RL1) one eight-bit mode byte sets serial framing
// (RL2) bits 1:0 pick rs232, four-wire, two-wire
// (RL3) bits 3:2 pick seven or eight data bits
// (RL4) bits 5:4 pick none, even, odd parity
// (RL5) bits 7:6 pick one or two stop bits
// (RL6) two-wire mode drives enable automatically, half duplex
// (RL7) driver enable polarity is configurable high or low
// (RL8) three pins each take a selectable function
// (RL9) software assigns driver enable to one pin only
// (RL10) setup console offered only in rs232 mode
// (RL11) enable up before sending, down once sent; the registered pin rises one clock after the start bit begins
// (RL12) outside two-wire mode enable stays inactive
`include "serial_mode_cfg.svh"
module serial_mode_txen
	import serial_mode_pkg::*;
#(
	parameter int BAUD_DIV = `SM_BAUD_DIV
) (
	// clock and reset
	input  wire logic        I_CLK,
	input  wire logic        I_RSTN,
	// mode byte
	input  wire logic        I_MODE_WE,
	input  wire logic [7:0]  I_MODE_WDATA,
	output logic [7:0]       O_MODE,
	output logic             O_SETUP_AVAIL,
	// pin configuration
	input  wire logic        I_PINCFG_WE,
	input  wire pin_fn_e     I_PIN1_FN,
	input  wire pin_fn_e     I_PIN2_FN,
	input  wire pin_fn_e     I_PIN3_FN,
	input  wire logic        I_TXEN_ACT_HIGH,
	output logic             O_PINCFG_ERR,
	// transmit stream
	input  wire logic        I_TX_VALID,
	input  wire logic [7:0]  I_TX_DATA,
	output logic             O_TX_READY,
	// receive stream
	output logic             O_RX_VALID,
	output logic [7:0]       O_RX_DATA,
	output logic             O_RX_PERR,
	output logic             O_RX_FERR,
	// serial line
	output logic             O_TXD,
	input  wire logic        I_RXD,
	// configurable pins
	input  wire logic [2:0]  I_CONFIG_PIN_IN,
	output logic [2:0]       O_CONFIG_PIN_OUT,
	output logic [2:0]       O_CONFIG_PIN_OE,
	// user side of pins
	input  wire logic [2:0]  I_PIN_OUTPUT,
	output logic [2:0]       O_PIN_INPUT,
	output logic             O_CARRIER,
	output logic             O_TX_BUSY
);
	localparam int CW = $clog2(BAUD_DIV);

	// ----------------------------------------
	// configuration state
	// ----------------------------------------
	logic [7:0]  mode;           // framing byte
	pin_fn_e     pin_fn [3];     // per-pin function
	logic        act_high;       // enable polarity
	logic        two_wire;       // half duplex with auto enable
	logic        len8;           // eight data bits
	logic        par_on;         // parity present
	logic        par_odd;        // odd parity
	logic        stop2;          // two stop bits
	logic [2:0]  txen_cnt;       // pins set to enable

	// mode byte write, reset value is rs232 8n1
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			mode <= `SM_MODE_RST;
		end else if (I_MODE_WE) begin
			mode <= I_MODE_WDATA; // RL1
		end
	end

	// pin functions and polarity
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			pin_fn[0] <= FN_IN;
			pin_fn[1] <= FN_IN;
			pin_fn[2] <= FN_IN;
			act_high  <= 1'b1;
		end else if (I_PINCFG_WE) begin
			pin_fn[0] <= I_PIN1_FN; // RL8
			pin_fn[1] <= I_PIN2_FN; // RL8
			pin_fn[2] <= I_PIN3_FN; // RL8
			act_high  <= I_TXEN_ACT_HIGH; // RL7
		end
	end

	// field decode; unlisted codes fall back to the plainer choice
	assign two_wire = (mode[`SM_IF_HI:`SM_IF_LO] == `SM_IF_TWO); // RL2 RL6
	assign len8     = (mode[`SM_LEN_HI:`SM_LEN_LO] == `SM_LEN_8); // RL3
	assign par_on   = (mode[`SM_PAR_HI:`SM_PAR_LO] == `SM_PAR_EVEN) ||
	                  (mode[`SM_PAR_HI:`SM_PAR_LO] == `SM_PAR_ODD); // RL4
	assign par_odd  = (mode[`SM_PAR_HI:`SM_PAR_LO] == `SM_PAR_ODD); // RL4
	assign stop2    = (mode[`SM_STOP_HI:`SM_STOP_LO] == `SM_STOP_2); // RL5

	assign O_MODE        = mode;
	assign O_SETUP_AVAIL = (mode[`SM_IF_HI:`SM_IF_LO] == `SM_IF_RS232); // RL10
	// flag a doubled enable assignment; behaviour is then undefined
	assign txen_cnt = 3'((pin_fn[0] == FN_TXEN)) + 3'((pin_fn[1] == FN_TXEN)) +
	                  3'((pin_fn[2] == FN_TXEN));
	assign O_PINCFG_ERR = (txen_cnt > 3'h1); // RL9

	// ----------------------------------------
	// transmit path
	// ----------------------------------------
	logic        fifo_valid;     // word waiting
	logic [7:0]  fifo_data;
	logic        fifo_take;      // engine pops a word
	line_st_e    tx_st;
	logic [CW-1:0] tx_cnt;       // baud divider
	logic        tx_tick;        // one-cycle bit-period enable
	logic [2:0]  tx_idx;         // data bit index
	logic        tx_stop_n;      // second stop bit pending
	logic [7:0]  tx_shift;       // bits still to send
	logic [7:0]  tx_word;        // whole character for parity
	logic        tx_par;         // parity bit of tx_word
	logic        cts_ok;         // flow control allows start

	serial_fifo #(.W(8), .DEPTH(`SM_FIFO_DEPTH)) u_tx_fifo (
		.i_clk   (I_CLK),
		.i_rstn  (I_RSTN),
		.i_valid (I_TX_VALID),
		.i_data  (I_TX_DATA),
		.o_ready (O_TX_READY),
		.o_valid (fifo_valid),
		.o_data  (fifo_data),
		.i_ready (fifo_take)
	);

	// clear to send only gates when pin one carries it
	assign cts_ok    = (pin_fn[0] != FN_HS_A) || I_CONFIG_PIN_IN[0];
	assign fifo_take = (tx_st == ST_IDLE) && fifo_valid && cts_ok;
	assign tx_tick   = (tx_st != ST_IDLE) && (tx_cnt == CW'(BAUD_DIV-1));
	// seven-bit mode ignores bit seven in the parity sum
	assign tx_par    = ^(tx_word & {len8, 7'h7F}) ^ par_odd; // RL4

	// baud divider, restarts with each character
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			tx_cnt <= '0;
		end else if (tx_st == ST_IDLE || tx_tick) begin
			tx_cnt <= '0;
		end else begin
			tx_cnt <= tx_cnt + 1'b1;
		end
	end

	// framing sequence; mode is read live, so change it only between frames
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			tx_st     <= ST_IDLE;
			tx_idx    <= '0;
			tx_stop_n <= 1'b0;
			tx_shift  <= '0;
			tx_word   <= '0;
			O_TXD     <= 1'b1;
		end else begin
			case (tx_st)
				ST_IDLE: begin
					O_TXD <= 1'b1;
					if (fifo_take) begin
						tx_word  <= fifo_data;
						tx_shift <= fifo_data;
						tx_st    <= ST_START;
						O_TXD    <= 1'b0;
					end
				end
				ST_START: begin
					if (tx_tick) begin
						O_TXD    <= tx_shift[0];
						tx_shift <= {1'b0, tx_shift[7:1]};
						tx_idx   <= '0;
						tx_st    <= ST_DATA;
					end
				end
				ST_DATA: begin
					if (tx_tick) begin
						if (tx_idx == (len8 ? 3'h7 : 3'h6)) begin // RL3
							if (par_on) begin
								O_TXD <= tx_par; // RL4
								tx_st <= ST_PAR;
							end else begin
								O_TXD     <= 1'b1;
								tx_stop_n <= stop2; // RL5
								tx_st     <= ST_STOP;
							end
						end else begin
							O_TXD    <= tx_shift[0];
							tx_shift <= {1'b0, tx_shift[7:1]};
							tx_idx   <= tx_idx + 1'b1;
						end
					end
				end
				ST_PAR: begin
					if (tx_tick) begin
						O_TXD     <= 1'b1;
						tx_stop_n <= stop2; // RL5
						tx_st     <= ST_STOP;
					end
				end
				ST_STOP: begin
					if (tx_tick) begin
						if (tx_stop_n) begin
							tx_stop_n <= 1'b0; // RL5
						end else begin
							tx_st <= ST_IDLE;
						end
					end
				end
				default: begin
					tx_st <= ST_IDLE;
				end
			endcase
		end
	end

	assign O_TX_BUSY = (tx_st != ST_IDLE);

	// ----------------------------------------
	// receive path
	// ----------------------------------------
	line_st_e    rx_st;
	logic [CW-1:0] rx_cnt;       // sample timer
	logic        rx_half;        // mid start bit
	logic        rx_tick;        // mid of later bits
	logic [2:0]  rx_idx;
	logic [7:0]  rx_shift;
	logic        rx_par;         // running parity
	logic        line_owned;     // our driver holds the pair
	logic        busy_q;         // busy one cycle late, like the enable pin

	// enable pin is registered: stay blind one cycle past the last stop bit
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= O_TX_BUSY;
		end
	end

	// two-wire receiver is blind while we drive the shared pair
	assign line_owned = two_wire && (O_TX_BUSY || busy_q); // RL6
	assign rx_half = (rx_st == ST_START) && (rx_cnt == CW'(BAUD_DIV/2));
	assign rx_tick = (rx_st != ST_IDLE) && (rx_st != ST_START) &&
	                 (rx_cnt == CW'(BAUD_DIV-1));

	// receive sample timer
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			rx_cnt <= '0;
		end else if (rx_st == ST_IDLE || rx_half || rx_tick) begin
			rx_cnt <= '0;
		end else begin
			rx_cnt <= rx_cnt + 1'b1;
		end
	end

	// receive framing, checks the first stop bit only
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			rx_st      <= ST_IDLE;
			rx_idx     <= '0;
			rx_shift   <= '0;
			rx_par     <= 1'b0;
			O_RX_VALID <= 1'b0;
			O_RX_DATA  <= '0;
			O_RX_PERR  <= 1'b0;
			O_RX_FERR  <= 1'b0;
		end else begin
			O_RX_VALID <= 1'b0;
			case (rx_st)
				ST_IDLE: begin
					if (!I_RXD && !line_owned) begin
						rx_st <= ST_START;
					end
				end
				ST_START: begin
					if (rx_half) begin
						rx_idx <= '0;
						rx_par <= par_odd;
						rx_st  <= I_RXD ? ST_IDLE : ST_DATA; // glitch rejected
					end
				end
				ST_DATA: begin
					if (rx_tick) begin
						rx_shift <= {I_RXD, rx_shift[7:1]};
						rx_par   <= rx_par ^ I_RXD;
						rx_idx   <= rx_idx + 1'b1;
						if (rx_idx == (len8 ? 3'h7 : 3'h6)) begin // RL3
							rx_st <= par_on ? ST_PAR : ST_STOP;
						end
					end
				end
				ST_PAR: begin
					if (rx_tick) begin
						O_RX_PERR <= rx_par ^ I_RXD; // RL4
						rx_st     <= ST_STOP;
					end
				end
				ST_STOP: begin
					if (rx_tick) begin
						O_RX_VALID <= 1'b1;
						O_RX_DATA  <= len8 ? rx_shift : {1'b0, rx_shift[7:1]};
						O_RX_FERR  <= !I_RXD;
						if (!par_on) begin
							O_RX_PERR <= 1'b0;
						end
						rx_st <= ST_IDLE;
					end
				end
				default: begin
					rx_st <= ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// pin multiplexer
	// ----------------------------------------
	logic txen_on;               // enable asserted logically
	logic txen_lvl;              // enable at pin polarity

	// raised with the start bit, dropped after the last stop bit
	assign txen_on  = two_wire && O_TX_BUSY; // RL11 RL12
	assign txen_lvl = txen_on ? act_high : !act_high; // RL7

	// registered pin drive; lamp lights on line activity on pins one and three, pin two is not driven
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			O_CONFIG_PIN_OUT <= '0;
			O_CONFIG_PIN_OE  <= '0;
			O_PIN_INPUT      <= '0;
			O_CARRIER        <= 1'b0;
		end else begin
			O_PIN_INPUT <= I_CONFIG_PIN_IN;
			O_CARRIER   <= (pin_fn[1] == FN_HS_A) && I_CONFIG_PIN_IN[1];
			for (int k = 0; k < 3; k++) begin
				case (pin_fn[k])
					FN_OUT: begin
						O_CONFIG_PIN_OE[k]  <= 1'b1; // RL8
						O_CONFIG_PIN_OUT[k] <= I_PIN_OUTPUT[k];
					end
					FN_LAMP: begin
						O_CONFIG_PIN_OE[k]  <= (k != 1);
						O_CONFIG_PIN_OUT[k] <= O_TX_BUSY || (rx_st != ST_IDLE);
					end
					FN_TXEN: begin
						O_CONFIG_PIN_OE[k]  <= 1'b1;
						O_CONFIG_PIN_OUT[k] <= txen_lvl; // RL7 RL12
					end
					FN_HS_A: begin
						// rts on pin three; cts and dcd are inputs
						O_CONFIG_PIN_OE[k]  <= (k == 2);
						O_CONFIG_PIN_OUT[k] <= (k == 2) && O_TX_BUSY;
					end
					FN_HS_B: begin
						// dtr exists on pin three only
						O_CONFIG_PIN_OE[k]  <= (k == 2);
						O_CONFIG_PIN_OUT[k] <= (k == 2);
					end
					default: begin
						O_CONFIG_PIN_OE[k]  <= 1'b0;
						O_CONFIG_PIN_OUT[k] <= 1'b0;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	logic [CW+1:0] stop_cyc;     // cycles spent in stop
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			stop_cyc <= '0;
		end else begin
			stop_cyc <= (tx_st == ST_STOP) ? stop_cyc + 1'b1 : '0;
		end
	end

	sequence tx_launch_s;
		tx_st == ST_IDLE && fifo_take;
	endsequence
	sequence tx_end_s;
		tx_st == ST_STOP && tx_tick && !tx_stop_n;
	endsequence

	mode_store_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // RL1
		I_MODE_WE |=> O_MODE == $past(I_MODE_WDATA))
		else $error("mode byte not stored");
	setup_gate_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // RL10
		(I_MODE_WE && I_MODE_WDATA[1:0] == 2'h3) |=> !O_SETUP_AVAIL)
		else $error("setup offered in two-wire mode");
	txen_rise_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // RL11
		(tx_launch_s and two_wire and pin_fn[0] == FN_TXEN) ##1 1
		|=> O_CONFIG_PIN_OUT[0] == act_high)
		else $error("enable not raised at start");
	txen_fall_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // RL11
		(tx_end_s and pin_fn[2] == FN_TXEN and !I_PINCFG_WE) ##1 !fifo_take
		|=> O_CONFIG_PIN_OUT[2] == !act_high)
		else $error("enable not dropped after stop");
	txen_idle_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // RL12
		(!two_wire && pin_fn[1] == FN_TXEN && !I_PINCFG_WE) [*2]
		|-> O_CONFIG_PIN_OUT[1] == !act_high && O_CONFIG_PIN_OE[1])
		else $error("enable active outside two-wire");
	stop_len_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // RL5
		tx_end_s |-> stop_cyc == (CW+2)'((stop2 ? 2 : 1) * BAUD_DIV - 1))
		else $error("stop period length wrong");
	par_bit_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // RL4
		(tx_st == ST_DATA && tx_tick && tx_idx == (len8 ? 3'h7 : 3'h6) && par_on)
		|=> tx_st == ST_PAR && O_TXD == $past(tx_par))
		else $error("parity bit wrong");
	rx_blind_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // RL6
		(rx_st == ST_IDLE && line_owned) |=> rx_st == ST_IDLE)
		else $error("receiver woke while driving");
	in_pin_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // RL8
		(pin_fn[0] == FN_IN && !I_PINCFG_WE) |=> !O_CONFIG_PIN_OE[0])
		else $error("input pin driven");

endmodule : serial_mode_txen

// ---- verif/xcvr_model.sv ----
// xcvr_model: two-wire line transceiver with failsafe bias and one remote node.
// assumes: driver enable arrives as a pin level, polarity given by i_act_high.
module xcvr_model (
	// device side
	input  wire logic i_de,
	input  wire logic i_act_high,
	input  wire logic i_txd,
	output logic      o_rxd,
	// remote node on the pair
	input  wire logic i_rem_en,
	input  wire logic i_rem_bit,
	output logic      o_line
);
	timeunit 1ns;
	timeprecision 100ps;
	logic drv; // our driver is on the pair
	assign drv = (i_de === i_act_high);
	// bias resistors pull an undriven pair to mark
	assign o_line = drv ? i_txd : (i_rem_en ? i_rem_bit : 1'b1);
	// receiver off while driving: inverse so stale data never looks good
	assign o_rxd = drv ? ~i_txd : o_line;
endmodule : xcvr_model

// ---- verif/serial_mode_txen_tb.sv ----
// serial_mode_txen_tb: mode byte, pins, framing, driver enable, rx and fifo.
// assumes: bit period shortened to 8 clocks; transceiver on the enable pin.
module serial_mode_txen_tb import serial_mode_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int BD = 8; // clocks per bit
	logic       clk, rstn, mode_we, pcfg_we, act_high, tx_valid, rem_en, rem_bit;
	logic       setup, cfg_err, tx_ready, rx_valid, rx_perr, rx_ferr, txd, rxd;
	logic       carrier, busy, line, got_rx;
	logic [7:0] mode_wdata, tx_data, mode, rx_data;
	logic [2:0] pin_drv, pin_out, pin_oe, user_out, pin_in, pin_wire;
	pin_fn_e    fn1, fn2, fn3;
	int         error_cnt, tests_run, cyc, p;
	// ----------------------------------------
	// clock, pins, partner, design
	// ----------------------------------------
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	// pin level: design when it drives, bench otherwise
	assign pin_wire = (pin_oe & pin_out) | (~pin_oe & pin_drv);
	// remember a receive pulse, it stands one cycle only
	always @(posedge clk) if (rx_valid === 1'b1) got_rx <= 1'b1;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			$display("Error at %0t: timeout", $time);
			tally_and_finish;
		end
	end
	xcvr_model i_xcvr (.i_de(pin_wire[p]), .i_act_high(act_high), .i_txd(txd),
		.o_rxd(rxd), .i_rem_en(rem_en), .i_rem_bit(rem_bit), .o_line(line));
	serial_mode_txen #(.BAUD_DIV(BD)) i_dut (.I_CLK(clk), .I_RSTN(rstn),
		.I_MODE_WE(mode_we), .I_MODE_WDATA(mode_wdata), .O_MODE(mode),
		.O_SETUP_AVAIL(setup), .I_PINCFG_WE(pcfg_we), .I_PIN1_FN(fn1), .I_PIN2_FN(fn2),
		.I_PIN3_FN(fn3), .I_TXEN_ACT_HIGH(act_high), .O_PINCFG_ERR(cfg_err),
		.I_TX_VALID(tx_valid), .I_TX_DATA(tx_data), .O_TX_READY(tx_ready),
		.O_RX_VALID(rx_valid), .O_RX_DATA(rx_data), .O_RX_PERR(rx_perr),
		.O_RX_FERR(rx_ferr), .O_TXD(txd), .I_RXD(rxd), .I_CONFIG_PIN_IN(pin_wire),
		.O_CONFIG_PIN_OUT(pin_out), .O_CONFIG_PIN_OE(pin_oe), .I_PIN_OUTPUT(user_out),
		.O_PIN_INPUT(pin_in), .O_CARRIER(carrier), .O_TX_BUSY(busy));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task tick;
		@(posedge clk);
		#1;
	endtask : tick
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr_mode(input logic [7:0] m);
		mode_wdata = m;
		mode_we = 1;
		tick;
		mode_we = 0;
		tick;
		chk(mode, m);
	endtask : wr_mode
	// pins answer two cycles after the write
	task automatic wr_pins(input pin_fn_e a, input pin_fn_e b, input pin_fn_e c,
		input logic ah);
		fn1 = a;
		fn2 = b;
		fn3 = c;
		act_high = ah;
		pcfg_we = 1;
		tick;
		pcfg_we = 0;
		repeat (2) tick;
	endtask : wr_pins
	// expected frame bits, start first, from the mode fields
	task automatic mk(input logic [7:0] m, input logic [7:0] d, output logic [11:0] f,
		output int tot);
		int n;
		logic par;
		n = (m[3:2] == 2'h3) ? 8 : 7;
		f = 12'hFFF;
		f[0] = 0;
		par = 0;
		for (int k = 0; k < n; k++) begin
			f[k+1] = d[k];
			par ^= d[k];
		end
		tot = 1 + n + ((m[7:6] == 2'h3) ? 2 : 1);
		if (m[5:4] == 2'h3 || m[5:4] == 2'h1) begin
			f[n+1] = (m[5:4] == 2'h3) ? par : ~par;
			tot++;
		end
	endtask : mk
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		chk(mode, 8'h4C);
		chk(setup, 1);
		chk(txd, 1);
		chk(pin_oe, 0);
		chk(tx_ready, 1);
		chk(busy, 0);
	endtask : t_reset
	task t_iface;
		for (int i = 0; i < 4; i++) begin
			wr_mode({6'h13, i[1:0]});
			chk(setup, i == 0);
		end
	endtask : t_iface
	// one frame per mode; enable pin and polarity rotate between frames
	task automatic t_tx;
		logic [7:0] ms [6] = '{8'h4C, 8'h78, 8'h4F, 8'hDB, 8'hFF, 8'h5D};
		logic [11:0] f;
		int tot, k;
		logic two;
		for (int i = 0; i < 6; i++) begin
			p = i % 3;
			wr_pins(p == 0 ? FN_TXEN : FN_IN, p == 1 ? FN_TXEN : FN_IN,
				p == 2 ? FN_TXEN : FN_IN, i[0]);
			chk(pin_oe[p], 1);
			chk(pin_wire[p], !i[0]);
			wr_mode(ms[i]);
			two = (ms[i][1:0] == 2'h3);
			mk(ms[i], 8'hB4 ^ i[7:0], f, tot);
			tx_data = 8'hB4 ^ i[7:0];
			tx_valid = 1;
			tick;
			tx_valid = 0;
			for (k = 0; k < 40 && txd !== 1'b0; k++) tick;
			repeat (BD / 2) tick;
			for (k = 0; k < tot; k++) begin
				chk(txd, f[k]);
				chk(pin_wire[p], two ? act_high : !act_high);
				if (two) chk(line, f[k]);
				repeat (BD) tick;
			end
			repeat (4) tick;
			chk(busy, 0);
			chk(pin_wire[p], !act_high);
		end
	endtask : t_tx
	task t_pins;
		user_out = 3'h5;
		wr_pins(FN_OUT, FN_OUT, FN_OUT, 1);
		chk(pin_oe, 3'h7);
		chk(pin_out, 3'h5);
		pin_drv = 3'h6;
		wr_pins(FN_IN, FN_HS_A, FN_IN, 1);
		chk(pin_oe, 3'h0);
		chk(pin_in, 3'h6);
		chk(carrier, 1);
		wr_pins(FN_LAMP, FN_LAMP, FN_HS_B, 1);
		chk(pin_oe, 3'h5);
		chk(pin_out[2], 1);
		wr_pins(FN_TXEN, FN_TXEN, FN_IN, 1);
		chk(cfg_err, 1);
		wr_pins(FN_IN, FN_IN, FN_TXEN, 1);
		chk(cfg_err, 0);
		// clear-to-send on pin one holds a waiting word back
		pin_drv = 3'h0;
		wr_pins(FN_HS_A, FN_IN, FN_IN, 1);
		tx_valid = 1;
		tick;
		tx_valid = 0;
		repeat (4) tick;
		chk(busy, 0);
		pin_drv = 3'h1;
		repeat (2) tick;
		chk(busy, 1);
		pin_drv = 3'h0;
		wr_pins(FN_IN, FN_IN, FN_IN, 1);
		// let the frame and any receive upset by pin toggling run out
		repeat (12 * BD) tick;
	endtask : t_pins
	// remote node sends one frame, bit bi flipped when nonzero
	task automatic t_rx(input logic [7:0] m, input logic [7:0] d, input int bi,
		input logic ep, input logic ef);
		logic [11:0] f;
		int tot;
		wr_mode(m);
		mk(m, d, f, tot);
		got_rx = 0;
		rem_en = 1;
		for (int k = 0; k < tot; k++) begin
			rem_bit = f[k] ^ (k == bi && bi != 0);
			repeat (BD) tick;
		end
		rem_en = 0;
		repeat (2 * BD) tick;
		chk(got_rx, 1);
		chk(rx_data, (m[3:2] == 2'h3) ? d : {1'b0, d[6:0]});
		chk(rx_perr, ep);
		chk(rx_ferr, ef);
	endtask : t_rx
	// fill until refused, then let the line drain it
	task t_fifo;
		int n;
		wr_mode(8'h4C);
		n = 0;
		// offer words only while taken, so a refused word is never swapped
		for (int k = 0; k < 20 && tx_ready === 1'b1; k++) begin
			tx_data = k[7:0];
			tx_valid = 1;
			n++;
			tick;
		end
		tx_valid = 0;
		chk(n, 17);
		chk(tx_ready, 0);
		repeat (17 * 10 * BD + 50) tick;
		chk(tx_ready, 1);
		chk(busy, 0);
	endtask : t_fifo
	task tally_and_finish;
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : tally_and_finish
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{rstn, mode_we, pcfg_we, tx_valid, rem_en} = 0;
		{act_high, rem_bit} = 2'h3;
		{mode_wdata, tx_data} = 0;
		{pin_drv, user_out} = 0;
		fn1 = FN_IN;
		fn2 = FN_IN;
		fn3 = FN_IN;
		{error_cnt, tests_run, cyc, p} = 0;
		got_rx = 0;
		repeat (3) @(posedge clk);
		#1;
		rstn = 1;
		t_reset;
		t_iface;
		t_tx;
		t_pins;
		t_rx(8'h7C, 8'hA6, 0, 0, 0);
		t_rx(8'h7C, 8'h5A, 9, 1, 0);
		t_rx(8'h7C, 8'h33, 10, 0, 1);
		t_rx(8'h78, 8'hE1, 0, 0, 0);
		t_rx(8'h5D, 8'h17, 0, 0, 0);
		t_rx(8'h4F, 8'hC8, 0, 0, 0);
		t_fifo;
		tally_and_finish;
	end
endmodule : serial_mode_txen_tb
